// ### sram_dual_port_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
`include "sram_arb_defs.svh"

module sram_dual_port_arbiter (
  input wire logic ref_clk, // 50 MHz system clock
  input wire logic reset, // Async reset, active high
  input wire logic portReq, // Data port request
  input wire logic portWrite, // Data port write
  input wire logic [`SRAM_ADDR_W-1:0] portAddr, // Data port word address
  input wire logic [`SRAM_DATA_W-1:0] portWdata, // Data port write data
  input wire logic [3:0] portBe, // Data port byte enables
  output logic portStall, // Data port wait
  output logic [`SRAM_DATA_W-1:0] portRdata, // Data port read data
  input wire logic busReq, // Bus side request, DMA and fetch
  input wire logic busWrite, // Bus write
  input wire logic [`SRAM_ADDR_W-1:0] busAddr, // Bus word address
  input wire logic [`SRAM_DATA_W-1:0] busWdata, // Bus write data
  input wire logic [3:0] busBe, // Bus byte enables
  output logic busWait, // Bus wait state
  output logic [`SRAM_DATA_W-1:0] busRdata, // Bus read data
  output logic busOwner, // Current owner, 1 is bus
  input wire logic switchoverEnable, // Firmware battery switchover setting
  input wire logic supplyGood, // Main supplies present
  input wire logic lowVoltageDetector, // Detector trip
  input wire logic batteryPresent, // Backup battery fitted
  output logic sramOnBattery, // SRAM on battery
  output logic rtcOnBattery // RTC on battery
);
  localparam int DEPTH = 1 << `SRAM_ADDR_W;

  logic [`SRAM_DATA_W-1:0] mem [DEPTH];
  logic owner_q;
  logic owner_d;
  logic pendBus_q;
  logic pendPort_q;
  logic [`SRAM_DATA_W-1:0] portRdata_q;
  logic [`SRAM_DATA_W-1:0] busRdata_q;
  wire logic both;
  wire logic grantBus;
  wire logic grantPort;
  wire logic access;
  wire logic selWrite;
  wire logic [`SRAM_ADDR_W-1:0] selAddr;
  wire logic [`SRAM_DATA_W-1:0] selWdata;
  wire logic [3:0] selBe;
  wire logic [`SRAM_DATA_W-1:0] mergedWord;

  // Grant decode: contention alternates against the last owner
  assign both = portReq && busReq;
  assign grantBus = both ? (owner_q == `OWNER_PORT) : busReq;
  assign grantPort = both ? (owner_q == `OWNER_BUS) : portReq;
  assign access = grantBus || grantPort;
  assign portStall = portReq && !grantPort;
  assign busWait = busReq && !grantBus;

  // Single SRAM port mux; one word per cycle to whoever holds the grant
  assign selWrite = grantBus ? busWrite : portWrite;
  assign selAddr = grantBus ? busAddr : portAddr;
  assign selWdata = grantBus ? busWdata : portWdata;
  assign selBe = grantBus ? busBe : portBe;

  // Owner only moves on a real access, so idle cycles keep it parked
  assign owner_d = grantBus ? `OWNER_BUS : (grantPort ? `OWNER_PORT : owner_q);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) owner_q <= `OWNER_RESET;
    else owner_q <= owner_d;
  end

  // Byte-lane merge, one generate per lane; untouched lanes keep old data
  genvar lane;
  generate
    for (lane = 0; lane < `SRAM_LANES; lane++) begin : g_lane
      assign mergedWord[lane*`LANE_W +: `LANE_W] = selBe[lane] ?
          selWdata[lane*`LANE_W +: `LANE_W] : mem[selAddr][lane*`LANE_W +: `LANE_W];
    end
  endgenerate

  // One writer for the whole array; per-lane writers would be multiple drivers
  always_ff @(posedge ref_clk) begin
    if (access && selWrite) mem[selAddr] <= mergedWord;
  end

  // Read data registered per requestor; held until that side reads again
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      portRdata_q <= 32'h0000_0000;
      busRdata_q <= 32'h0000_0000;
    end else begin
      if (grantPort && !portWrite) portRdata_q <= mem[portAddr];
      if (grantBus && !busWrite) busRdata_q <= mem[busAddr];
    end
  end

  assign portRdata = portRdata_q;
  assign busRdata = busRdata_q;
  assign busOwner = owner_q;

  backup_switch u_backup (
    .ref_clk(ref_clk),
    .reset(reset),
    .supplyGood(supplyGood),
    .lowVoltageDetector(lowVoltageDetector),
    .batteryPresent(batteryPresent),
    .switchoverEnable(switchoverEnable),
    .sramOnBattery(sramOnBattery),
    .rtcOnBattery(rtcOnBattery)
  );

  // Helper: each side waited last cycle under contention
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pendBus_q <= 1'b0;
      pendPort_q <= 1'b0;
    end else begin
      pendBus_q <= busWait;
      pendPort_q <= portStall;
    end
  end

  sequence s_both;
    portReq && busReq;
  endsequence

  // Data port holds the SRAM this cycle
  sequence s_portTurn;
    portReq && !portStall;
  endsequence

  property p_lonePort;
    @(posedge ref_clk) disable iff (reset)
      (portReq && !busReq) |-> !portStall;
  endproperty
  a_lonePort: assert property (p_lonePort)
    else $error("Lone data port request stalled");

  property p_loneBus;
    @(posedge ref_clk) disable iff (reset)
      (busReq && !portReq) |-> !busWait;
  endproperty
  a_loneBus: assert property (p_loneBus)
    else $error("Lone bus request waited");

  property p_alternate;
    @(posedge ref_clk) disable iff (reset)
      s_both ##1 s_both |-> (grantBus != $past(grantBus));
  endproperty
  a_alternate: assert property (p_alternate)
    else $error("Contention did not alternate");

  property p_noStarve;
    @(posedge ref_clk) disable iff (reset)
      (pendBus_q && busReq) |-> !busWait;
  endproperty
  a_noStarve: assert property (p_noStarve)
    else $error("Bus waited two cycles in a row");

  property p_park;
    @(posedge ref_clk) disable iff (reset)
      (!portReq && !busReq) |=> (busOwner == $past(busOwner));
  endproperty
  a_park: assert property (p_park)
    else $error("Grant moved while idle");

  property p_oneStall;
    @(posedge ref_clk) disable iff (reset)
      s_both |-> (portStall != busWait);
  endproperty
  a_oneStall: assert property (p_oneStall)
    else $error("Contention must stall exactly one side");

  property p_portOneCycle;
    @(posedge ref_clk) disable iff (reset)
      (grantPort && !portWrite) |=> (portRdata == mem[$past(portAddr)]);
  endproperty
  a_portOneCycle: assert property (p_portOneCycle)
    else $error("Data port read not ready next cycle");

  property p_ownerBus;
    @(posedge ref_clk) disable iff (reset)
      grantBus |=> busOwner;
  endproperty
  a_ownerBus: assert property (p_ownerBus)
    else $error("Owner not bus after bus access");

  // Port side is not starved either
  property p_portTurn;
    @(posedge ref_clk) disable iff (reset)
      (pendPort_q && portReq) |-> !portStall;
  endproperty
  a_portTurn: assert property (p_portTurn)
    else $error("Data port stalled two cycles in a row");

  property p_portOwner;
    @(posedge ref_clk) disable iff (reset)
      grantPort |=> !busOwner;
  endproperty
  a_portOwner: assert property (p_portOwner)
    else $error("Owner not port after port access");

  property p_busOneCycle;
    @(posedge ref_clk) disable iff (reset)
      (grantBus && !busWrite) |=> (busRdata == mem[$past(busAddr)]);
  endproperty
  a_busOneCycle: assert property (p_busOneCycle)
    else $error("Bus read not ready next cycle");

  // Read data must not drift between granted reads
  property p_portHold;
    @(posedge ref_clk) disable iff (reset)
      !(grantPort && !portWrite) |=> $stable(portRdata);
  endproperty
  a_portHold: assert property (p_portHold)
    else $error("Data port read data changed without a read");

  property p_writeLands;
    @(posedge ref_clk) disable iff (reset)
      (grantPort && portWrite && (&portBe)) |=> (mem[$past(portAddr)] == $past(portWdata));
  endproperty
  a_writeLands: assert property (p_writeLands)
    else $error("Data port write did not land in one cycle");

  // A bus wait is only legal while the port is being served
  property p_busWaitWhy;
    @(posedge ref_clk) disable iff (reset)
      busWait |-> s_portTurn;
  endproperty
  a_busWaitWhy: assert property (p_busWaitWhy)
    else $error("Bus waited with no port access");
endmodule

`default_nettype wire

// ### sram_arb_defs.svh
`ifndef SRAM_ARB_DEFS_SVH
`define SRAM_ARB_DEFS_SVH

// SRAM word and address geometry
`define SRAM_DATA_W 32
`define SRAM_ADDR_W 15
// Byte lanes per word and lane width
`define SRAM_LANES 4
`define LANE_W 8
// Grant owner codes
`define OWNER_PORT 1'b0
`define OWNER_BUS 1'b1
// Owner after reset
`define OWNER_RESET 1'b0
// Switchover enable after reset
`define SWITCH_EN_RESET 1'b1

`endif

// ### sram_arb_pkg.sv
package sram_arb_pkg;
  typedef enum logic [1:0] {
    SUPPLY_MAIN = 2'b00,
    SUPPLY_BATT = 2'b01,
    SUPPLY_RTC_ONLY = 2'b10
  } supply_state_t;
endpackage

// ### backup_switch.sv
`timescale 1ns/1ps
`default_nettype none
`include "sram_arb_defs.svh"

module backup_switch (
  input wire logic ref_clk, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic supplyGood, // Main supplies present, async pin
  input wire logic lowVoltageDetector, // Detector trip, async pin
  input wire logic batteryPresent, // Backup battery sensed, async pin
  input wire logic switchoverEnable, // Firmware setting, same clock
  output logic sramOnBattery, // SRAM powered from battery
  output logic rtcOnBattery // RTC powered from battery
);
  logic [2:0] goodSync_q;
  logic [2:0] lvdSync_q;
  logic [2:0] battSync_q;
  logic good_q;
  logic lvd_q;
  logic batt_q;
  sram_arb_pkg::supply_state_t state_q;
  sram_arb_pkg::supply_state_t state_d;
  wire logic supplyLost;

  // Three-stage sync; a level is accepted once stages two and three agree
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      goodSync_q <= 3'h0;
      lvdSync_q <= 3'h0;
      battSync_q <= 3'h0;
    end else begin
      goodSync_q <= {goodSync_q[1:0], supplyGood};
      lvdSync_q <= {lvdSync_q[1:0], lowVoltageDetector};
      battSync_q <= {battSync_q[1:0], batteryPresent};
    end
  end

  // Filtered levels only move on agreement, rejecting one-stage glitches
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      good_q <= 1'b0;
      lvd_q <= 1'b0;
      batt_q <= 1'b0;
    end else begin
      if (goodSync_q[1] == goodSync_q[2]) good_q <= goodSync_q[2];
      if (lvdSync_q[1] == lvdSync_q[2]) lvd_q <= lvdSync_q[2];
      if (battSync_q[1] == battSync_q[2]) batt_q <= battSync_q[2];
    end
  end

  assign supplyLost = !good_q || lvd_q;

  // Supply selection; battery only chosen when one is fitted
  always_comb begin
    state_d = sram_arb_pkg::SUPPLY_MAIN;
    case ({supplyLost, batt_q, switchoverEnable})
      3'b111: state_d = sram_arb_pkg::SUPPLY_BATT;
      3'b110: state_d = sram_arb_pkg::SUPPLY_RTC_ONLY;
      default: state_d = sram_arb_pkg::SUPPLY_MAIN;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) state_q <= sram_arb_pkg::SUPPLY_MAIN;
    else state_q <= state_d;
  end

  assign sramOnBattery = (state_q == sram_arb_pkg::SUPPLY_BATT);
  assign rtcOnBattery = (state_q != sram_arb_pkg::SUPPLY_MAIN);

  // Battery takes the SRAM one edge after the filtered condition
  property p_battSwitch;
    @(posedge ref_clk) disable iff (reset)
      (supplyLost && batt_q && switchoverEnable) |=> (sramOnBattery && rtcOnBattery);
  endproperty
  a_battSwitch: assert property (p_battSwitch)
    else $error("SRAM not switched to battery");

  // Disabled switchover leaves only the RTC on the battery
  property p_rtcOnly;
    @(posedge ref_clk) disable iff (reset)
      (supplyLost && batt_q && !switchoverEnable) |=> (rtcOnBattery && !sramOnBattery);
  endproperty
  a_rtcOnly: assert property (p_rtcOnly)
    else $error("RTC not alone on battery");
  property p_switchOff;
    @(posedge ref_clk) disable iff (reset)
      !switchoverEnable |=> !sramOnBattery;
  endproperty
  a_switchOff: assert property (p_switchOff)
    else $error("SRAM on battery while switchover disabled");
endmodule

`default_nettype wire

// ### requestor_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "sram_arb_defs.svh"

module requestor_model (
  input wire logic clk, // System clock
  input wire logic stall, // Not taken this cycle
  input wire logic [`SRAM_DATA_W-1:0] rdata, // Read data
  output logic req, // Request
  output logic write, // Write when high
  output logic [`SRAM_ADDR_W-1:0] addr, // Word address
  output logic [`SRAM_DATA_W-1:0] wdata, // Write data
  output logic [3:0] be // Byte lanes
);
  // Lanes used by the next access; the bench may narrow it
  logic [3:0] beMask = 4'hF;

  // Idle at time zero
  initial begin
    req = 1'b0;
    write = 1'b0;
    addr = '0;
    wdata = '0;
    be = 4'h0;
  end

  // One word per call on the beMask lanes, held until taken or 8 waits; DMA and fetch share this path
  task automatic access(input logic wr, input logic [`SRAM_ADDR_W-1:0] a,
      input logic [`SRAM_DATA_W-1:0] d, output logic [`SRAM_DATA_W-1:0] q,
      output int waits);
    @(negedge clk);
    req = 1'b1;
    write = wr;
    addr = a;
    wdata = d;
    be = beMask;
    waits = 0;
    #1;
    while (stall !== 1'b0 && waits < 8) begin
      @(negedge clk);
      #1;
      waits++;
    end
    @(negedge clk);
    // Released address and data inverted so stale values cannot look valid
    req = 1'b0;
    addr = ~a;
    wdata = ~d;
    be = 4'h0;
    q = rdata;
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sram_arb_defs.svh"

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin nErrors++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end

module tb_top;
  logic ref_clk, reset, switchoverEnable, supplyGood, lowVoltageDetector, batteryPresent;
  logic portReq, portWrite, portStall, busReq, busWrite, busWait, busOwner;
  logic sramOnBattery, rtcOnBattery;
  logic [`SRAM_ADDR_W-1:0] portAddr, busAddr;
  logic [`SRAM_DATA_W-1:0] portWdata, portRdata, busWdata, busRdata, q;
  logic [3:0] portBe, busBe;
  int nErrors = 0;
  int checked = 0;
  int pw, bw;

  sram_dual_port_arbiter uut (.ref_clk(ref_clk), .reset(reset), .portReq(portReq),
    .portWrite(portWrite), .portAddr(portAddr), .portWdata(portWdata), .portBe(portBe),
    .portStall(portStall), .portRdata(portRdata), .busReq(busReq), .busWrite(busWrite),
    .busAddr(busAddr), .busWdata(busWdata), .busBe(busBe), .busWait(busWait),
    .busRdata(busRdata), .busOwner(busOwner), .switchoverEnable(switchoverEnable),
    .supplyGood(supplyGood), .lowVoltageDetector(lowVoltageDetector),
    .batteryPresent(batteryPresent), .sramOnBattery(sramOnBattery),
    .rtcOnBattery(rtcOnBattery));
  // Data port and system bus requestors
  requestor_model pm (.clk(ref_clk), .stall(portStall), .rdata(portRdata), .req(portReq),
    .write(portWrite), .addr(portAddr), .wdata(portWdata), .be(portBe));
  requestor_model bm (.clk(ref_clk), .stall(busWait), .rdata(busRdata), .req(busReq),
    .write(busWrite), .addr(busAddr), .wdata(busWdata), .be(busBe));

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Lone requestors, data crossing sides
  task automatic lone_access();
    pm.access(1'b1, 15'h0010, 32'hA5A50001, q, pw);
    `CHK(pw, 0)
    bm.access(1'b0, 15'h0010, 32'h00000000, q, bw);
    `CHK(bw, 0)
    `CHK(q, 32'hA5A50001)
    bm.access(1'b1, 15'h0020, 32'h5A5A0002, q, bw);
    pm.access(1'b0, 15'h0020, 32'h00000000, q, pw);
    `CHK(pw, 0)
    `CHK(q, 32'h5A5A0002)
    $display("test lone_access done");
  endtask

  // Grant stays parked on last user
  task automatic parking();
    bm.access(1'b0, 15'h0010, 32'h00000000, q, bw);
    repeat (3) @(negedge ref_clk);
    `CHK(busOwner, `OWNER_BUS)
    bm.access(1'b0, 15'h0020, 32'h00000000, q, bw);
    `CHK(bw, 0)
    $display("test parking done");
  endtask

  // Simultaneous requests: last user yields one cycle
  task automatic contention();
    logic [`SRAM_DATA_W-1:0] pq, bq;
    pm.access(1'b0, 15'h0010, 32'h00000000, pq, pw);
    fork
      pm.access(1'b0, 15'h0010, 32'h00000000, pq, pw);
      bm.access(1'b0, 15'h0020, 32'h00000000, bq, bw);
    join
    `CHK(bw, 0)
    `CHK(pw, 1)
    `CHK(pq, 32'hA5A50001)
    `CHK(bq, 32'h5A5A0002)
    bm.access(1'b0, 15'h0010, 32'h00000000, bq, bw);
    fork
      pm.access(1'b1, 15'h0030, 32'h0BADF00D, pq, pw);
      bm.access(1'b0, 15'h0020, 32'h00000000, bq, bw);
    join
    `CHK(pw, 0)
    `CHK(bw, 1)
    bm.access(1'b0, 15'h0030, 32'h00000000, bq, bw);
    `CHK(bq, 32'h0BADF00D)
    $display("test contention done");
  endtask

  // Supply event, then recovery; worst latency is five edges
  task automatic batt_case(input logic g, input logic l, input logic b, input logic en,
      input logic es, input logic er);
    @(negedge ref_clk);
    supplyGood = g;
    lowVoltageDetector = l;
    batteryPresent = b;
    switchoverEnable = en;
    repeat (6) @(negedge ref_clk);
    `CHK(sramOnBattery, es)
    `CHK(rtcOnBattery, er)
    supplyGood = 1'b1;
    lowVoltageDetector = 1'b0;
    repeat (6) @(negedge ref_clk);
    `CHK(sramOnBattery, 1'b0)
    `CHK(rtcOnBattery, 1'b0)
  endtask

  // Partial byte lanes keep the untouched lanes
  task automatic lanes();
    pm.beMask = 4'h3;
    pm.access(1'b1, 15'h0010, 32'h11112222, q, pw);
    pm.beMask = 4'hF;
    bm.access(1'b0, 15'h0010, 32'h00000000, q, bw);
    `CHK(q, 32'hA5A52222)
    $display("test lanes done");
  endtask

  task automatic battery();
    batt_case(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    batt_case(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    batt_case(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    batt_case(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    $display("test battery done");
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    switchoverEnable = 1'b1;
    supplyGood = 1'b1;
    lowVoltageDetector = 1'b0;
    batteryPresent = 1'b1;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    lone_access();
    parking();
    contention();
    lanes();
    battery();
    stop_test();
  end

  // Hang guard, well past the hundred or so cycles the tests need
  initial begin
    #100000;
    nErrors++;
    $display("mismatch at %0t: timeout", $time);
    stop_test();
  end
endmodule
`default_nettype wire
